// *** src/ddstw_pkg.sv ***
package ddstw_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int TW_W = 48;
  localparam int OFF_W = 16;
  localparam int LIM_W = 24;
  localparam int TMR_W = 24;
  localparam int SUM_W = TW_W + TMR_W;
  localparam int REM_W = TMR_W + 1;
  localparam int STEP_W = 7;
  localparam int MS_CNT_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;
  localparam int BYTE_LSB = 2;
  localparam int OPT_W = 8;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [IDX_W-1:0] IDX_FTW_LO = 12'h300;
  localparam logic [IDX_W-1:0] IDX_FTW_HI = 12'h301;
  localparam logic [IDX_W-1:0] IDX_CLAMP_LO = 12'h307;
  localparam logic [IDX_W-1:0] IDX_CLAMP_HI = 12'h308;
  localparam logic [IDX_W-1:0] IDX_PHASE = 12'h30d;
  localparam logic [IDX_W-1:0] IDX_TIMER = 12'h318;
  localparam logic [IDX_W-1:0] IDX_OPTIONS = 12'h31b;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 12'ha03;
  localparam logic [IDX_W-1:0] IDX_HIST_LO = 12'hd14;
  localparam logic [IDX_W-1:0] IDX_HIST_HI = 12'hd15;
  localparam logic [IDX_W-1:0] IDX_STATUS = 12'hd1a;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int OPT_K_LSB = 0;
  localparam int OPT_K_MSB = 2;
  localparam int OPT_PERSIST_BIT = 3;
  localparam int OPT_FALLBACK_BIT = 4;
  localparam int CTRL_CLEAR_BIT = 2;
  localparam logic [LIM_W-1:0] CLAMP_HI_RST = 24'hffffff;
  localparam logic [TMR_W-1:0] TIMER_RST = 24'h000001;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;
  localparam logic [STEP_W-1:0] DIV_STEPS = 7'h48;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {DDSTW_FREE_RUN, DDSTW_CLOSED, DDSTW_HOLDOVER} ddstw_mode_t;
  typedef enum logic {DIV_IDLE, DIV_RUN} ddstw_div_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ddstw_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } ddstw_apb_rsp_t;

  typedef struct packed {
    ddstw_mode_t mode;
    logic ref_switch;
    logic [TW_W-1:0] filter_word;
  } ddstw_loop_t;

  typedef struct packed {
    logic [TW_W-1:0] acc, phase, tw, tuning_step_word, last_closed, hist, quot;
    logic [LIM_W-1:0] clamp_lo, clamp_hi;
    logic [TMR_W-1:0] timer, elapsed, ckpt, cnt, divisor;
    logic [OFF_W-1:0] offset;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [OPT_W-1:0] options;
    logic [SUM_W-1:0] sum, dividend;
    logic [REM_W-1:0] rem;
    logic [STEP_W-1:0] div_step;
    ddstw_div_t div_state;
    logic valid, first, strobe;
    logic pin_meta, pin_sync, pin_prev;
    ddstw_apb_rsp_t rsp;
  } ddstw_state_t;

endpackage

// *** src/ddstw_core.sv ***
// Operation
// - accumulator adds the 48-bit tuning step word every cycle, wrapping modulo 2^48.
// - output frequency is step word over 2^48 times the sample clock.
// - 16-bit phase offset shifts output phase by offset over 2^16 cycles.
// - free-run mode feeds the free-running tuning word register to the accumulator.
// - closed loop feeds the loop filter output to the accumulator.
// - holdover feeds the averaged history tuning word.
// - holdover without history uses fallback bit: free-run word or last instantaneous word.
// - every mode clamps the step word between 24-bit upper and lower limits.
// - inside the limits the selected step word passes unchanged.
// - after reset the limits span zero to the sample frequency.
// - history averages filter words over a 24-bit millisecond interval, minimum 1 ms.
// - each interval average is independent and written to the history register.
// - each interval end gives a strobe usable as interrupt and pin output.
// - a new reference restarts accumulation and by default discards history.
// - with persistent bit set, history survives a reference switch.
// - software control bit or multifunction pin clears the history.
// - without history the first value is stored after a full interval.
// - after clear, K gives intermediate averages at T/2^K doubling to T.
// - after the first interval averages come every full interval.
module ddstw_core #(
  parameter int unsigned MS_CYCLES = ddstw_pkg::MS_CYCLES_DFLT
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // register bus
  input wire ddstw_pkg::ddstw_apb_req_t APB_REQ,
  output ddstw_pkg::ddstw_apb_rsp_t APB_RSP,
  // loop filter and loop control
  input wire ddstw_pkg::ddstw_loop_t LOOP_IN,
  // multifunction pin, asynchronous
  input wire logic CLEAR_HIST_PIN,
  // synthesizer outputs
  output logic [ddstw_pkg::TW_W-1:0] PHASE_OUT,
  output logic [ddstw_pkg::TW_W-1:0] TUNING_WORD,
  output logic HIST_STROBE,
  output logic HIST_VALID
);
  import ddstw_pkg::*;

  ddstw_state_t st_reg;
  ddstw_state_t st_next;
  logic [TW_W-1:0] tw_sel;
  logic [TW_W-1:0] tw_clamped;
  logic [TW_W-1:0] lo_word;
  logic [TW_W-1:0] hi_word;
  logic clear_evt;
  logic div_done;
  logic ms_tick;
  logic [IDX_W-1:0] idx;
  logic [SUM_W-1:0] sum_n;
  logic [TMR_W-1:0] el_n;
  logic [TMR_W-1:0] ckpt_init;
  logic [TMR_W:0] ckpt_dbl;
  logic [REM_W-1:0] rem_sh;
  logic sw_clear;
  logic persist;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.strobe = 1'b0;
    sw_clear = 1'b0;
    div_done = 1'b0;
    sum_n = '0;
    el_n = '0;
    rem_sh = '0;
    tw_sel = st_reg.tuning_step_word;
    idx = APB_REQ.paddr[ADDR_W-1:BYTE_LSB];
    persist = st_reg.options[OPT_PERSIST_BIT];
    ms_tick = (st_reg.ms_cnt == MS_CNT_W'(MS_CYCLES - 1));

    // pin synchroniser, rising edge taken from the second stage onward
    st_next.pin_meta = CLEAR_HIST_PIN;
    st_next.pin_sync = st_reg.pin_meta;
    st_next.pin_prev = st_reg.pin_sync;

    // apb: answer registered in the setup cycle, so no wait states
    st_next.rsp.pready = 1'b0;
    st_next.rsp.pslverr = 1'b0;
    st_next.rsp.prdata = '0;
    if (APB_REQ.psel && !APB_REQ.penable) begin
      st_next.rsp.pready = 1'b1;
      unique case (idx)
        IDX_FTW_LO: st_next.rsp.prdata = st_reg.tuning_step_word[DATA_W-1:0];
        IDX_FTW_HI: st_next.rsp.prdata = DATA_W'(st_reg.tuning_step_word[TW_W-1:DATA_W]);
        IDX_CLAMP_LO: st_next.rsp.prdata = DATA_W'(st_reg.clamp_lo);
        IDX_CLAMP_HI: st_next.rsp.prdata = DATA_W'(st_reg.clamp_hi);
        IDX_PHASE: st_next.rsp.prdata = DATA_W'(st_reg.offset);
        IDX_TIMER: st_next.rsp.prdata = DATA_W'(st_reg.timer);
        IDX_OPTIONS: st_next.rsp.prdata = DATA_W'(st_reg.options);
        IDX_CONTROL: st_next.rsp.prdata = '0;
        IDX_HIST_LO: st_next.rsp.prdata = st_reg.hist[DATA_W-1:0];
        IDX_HIST_HI: st_next.rsp.prdata = DATA_W'(st_reg.hist[TW_W-1:DATA_W]);
        IDX_STATUS: begin
          st_next.rsp.prdata = DATA_W'({st_reg.div_state == DIV_RUN, st_reg.first, st_reg.valid});
        end
        default: st_next.rsp.pslverr = 1'b1;
      endcase
    end
    if (APB_REQ.psel && APB_REQ.penable && st_reg.rsp.pready && APB_REQ.pwrite) begin
      unique case (idx)
        IDX_FTW_LO: st_next.tuning_step_word[DATA_W-1:0] = APB_REQ.pwdata;
        IDX_FTW_HI: st_next.tuning_step_word[TW_W-1:DATA_W] = APB_REQ.pwdata[TW_W-DATA_W-1:0];
        IDX_CLAMP_LO: st_next.clamp_lo = APB_REQ.pwdata[LIM_W-1:0];
        IDX_CLAMP_HI: st_next.clamp_hi = APB_REQ.pwdata[LIM_W-1:0];
        IDX_PHASE: st_next.offset = APB_REQ.pwdata[OFF_W-1:0];
        IDX_TIMER: st_next.timer = APB_REQ.pwdata[TMR_W-1:0];
        IDX_OPTIONS: st_next.options = APB_REQ.pwdata[OPT_W-1:0];
        IDX_CONTROL: sw_clear = APB_REQ.pwdata[CTRL_CLEAR_BIT];
        default: ;
      endcase
    end

    // tuning word source
    unique case (LOOP_IN.mode)
      DDSTW_FREE_RUN: tw_sel = st_reg.tuning_step_word;
      DDSTW_CLOSED: tw_sel = LOOP_IN.filter_word;
      DDSTW_HOLDOVER: begin
        if (st_reg.valid) begin
          tw_sel = st_reg.hist;
        end else if (st_reg.options[OPT_FALLBACK_BIT]) begin
          tw_sel = st_reg.last_closed;
        end else begin
          tw_sel = st_reg.tuning_step_word;
        end
      end
      default: tw_sel = st_reg.tuning_step_word;
    endcase

    // clamp: limits are the top 24 bits; the upper one fills the rest with ones
    lo_word = {st_reg.clamp_lo, {(TW_W-LIM_W){1'b0}}};
    hi_word = {st_reg.clamp_hi, {(TW_W-LIM_W){1'b1}}};
    if (tw_sel < lo_word) begin
      tw_clamped = lo_word;
    end else if (tw_sel > hi_word) begin
      tw_clamped = hi_word;
    end else begin
      tw_clamped = tw_sel;
    end
    st_next.tw = tw_clamped;
    st_next.acc = st_reg.acc + tw_clamped;
    st_next.phase = st_next.acc + {st_reg.offset, {(TW_W-OFF_W){1'b0}}};
    if (LOOP_IN.mode == DDSTW_CLOSED) begin
      st_next.last_closed = tw_clamped;
    end

    // restoring divider, one quotient bit per cycle
    // one bit a cycle trades latency for area; a millisecond must outlast all 72 steps
    unique case (st_reg.div_state)
      DIV_IDLE: ;
      DIV_RUN: begin
        rem_sh = {st_reg.rem[REM_W-2:0], st_reg.dividend[SUM_W-1]};
        st_next.dividend = {st_reg.dividend[SUM_W-2:0], 1'b0};
        if (rem_sh >= {1'b0, st_reg.divisor}) begin
          st_next.rem = rem_sh - {1'b0, st_reg.divisor};
          st_next.quot = {st_reg.quot[TW_W-2:0], 1'b1};
        end else begin
          st_next.rem = rem_sh;
          st_next.quot = {st_reg.quot[TW_W-2:0], 1'b0};
        end
        st_next.div_step = st_reg.div_step - 1'b1;
        if (st_reg.div_step == STEP_W'(1)) begin
          div_done = 1'b1;
          st_next.div_state = DIV_IDLE;
        end
      end
    endcase

    // history accumulation, one filter sample per millisecond of closed loop
    // words seen in free run or holdover would bias the average, so they are skipped
    st_next.ms_cnt = ms_tick ? '0 : st_reg.ms_cnt + 1'b1;
    ckpt_dbl = {st_reg.ckpt, 1'b0};
    if (ms_tick && LOOP_IN.mode == DDSTW_CLOSED) begin
      sum_n = st_reg.sum + SUM_W'(LOOP_IN.filter_word);
      el_n = st_reg.elapsed + 1'b1;
      st_next.sum = sum_n;
      st_next.cnt = st_reg.cnt + 1'b1;
      st_next.elapsed = el_n;
      if (el_n >= st_reg.ckpt) begin
        st_next.dividend = sum_n;
        st_next.divisor = st_reg.cnt + 1'b1;
        st_next.rem = '0;
        st_next.quot = '0;
        st_next.div_step = DIV_STEPS;
        st_next.div_state = DIV_RUN;
        if (el_n >= st_reg.timer) begin
          // a fresh interval starts from an empty sum, not a moving window
          st_next.sum = '0;
          st_next.cnt = '0;
          st_next.elapsed = '0;
          st_next.first = 1'b0;
          st_next.ckpt = st_reg.timer;
        end else if (ckpt_dbl > {1'b0, st_reg.timer}) begin
          st_next.ckpt = st_reg.timer;
        end else begin
          st_next.ckpt = ckpt_dbl[TMR_W-1:0];
        end
      end
    end

    // restart and clear
    ckpt_init = st_reg.timer >> st_reg.options[OPT_K_MSB:OPT_K_LSB];
    if (st_reg.options[OPT_K_MSB:OPT_K_LSB] == '0) begin
      ckpt_init = st_reg.timer;
    end else if (ckpt_init == '0) begin
      ckpt_init = TMR_ONE;
    end
    clear_evt = sw_clear || (st_reg.pin_sync && !st_reg.pin_prev)
             || (LOOP_IN.ref_switch && !persist);
    if (LOOP_IN.ref_switch && persist) begin
      st_next.sum = '0;
      st_next.cnt = '0;
      st_next.elapsed = '0;
      st_next.ms_cnt = '0;
      st_next.first = 1'b0;
      st_next.ckpt = st_reg.timer;
    end
    if (clear_evt) begin
      st_next.valid = 1'b0;
      st_next.sum = '0;
      st_next.cnt = '0;
      st_next.elapsed = '0;
      st_next.ms_cnt = '0;
      st_next.first = 1'b1;
      st_next.ckpt = ckpt_init;
      st_next.div_state = DIV_IDLE;
    end
    // a timer written after the first interval applies at once, so later
    // averages never run on a stale checkpoint of the old period
    if (!st_next.first) begin
      st_next.ckpt = st_next.timer;
    end
    // a finishing average outranks a clear in the same cycle
    if (div_done) begin
      st_next.hist = st_next.quot;
      st_next.valid = 1'b1;
      st_next.strobe = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
      st_reg.clamp_hi <= CLAMP_HI_RST;
      st_reg.timer <= TIMER_RST;
      st_reg.ckpt <= TIMER_RST;
      st_reg.first <= 1'b1;
      st_reg.div_state <= DIV_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign APB_RSP = st_reg.rsp;
  assign PHASE_OUT = st_reg.phase;
  assign TUNING_WORD = st_reg.tw;
  assign HIST_STROBE = st_reg.strobe;
  assign HIST_VALID = st_reg.valid;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic in_range;
  assign in_range = (tw_sel >= lo_word) && (tw_sel <= hi_word);

  acc_step_a: assert property (
    !$past(SYS_RST) |-> st_reg.acc == TW_W'($past(st_reg.acc) + st_reg.tw))
    else $error("accumulator did not advance by the applied step");
  phase_offset_a: assert property (
    !$past(SYS_RST) |-> PHASE_OUT == TW_W'(st_reg.acc + {$past(st_reg.offset), 32'h0}))
    else $error("phase output lost its offset");
  free_run_sel_a: assert property (
    LOOP_IN.mode == DDSTW_FREE_RUN && in_range |=> TUNING_WORD == $past(st_reg.tuning_step_word))
    else $error("free-run word not applied");
  closed_sel_a: assert property (
    LOOP_IN.mode == DDSTW_CLOSED && in_range |=> TUNING_WORD == $past(LOOP_IN.filter_word))
    else $error("loop filter word not applied");
  holdover_hist_a: assert property (
    LOOP_IN.mode == DDSTW_HOLDOVER && st_reg.valid && in_range
    |=> TUNING_WORD == $past(st_reg.hist))
    else $error("history word not applied in holdover");
  fallback_sel_a: assert property (
    LOOP_IN.mode == DDSTW_HOLDOVER && !st_reg.valid && in_range
    |=> TUNING_WORD == ($past(st_reg.options[OPT_FALLBACK_BIT]) ?
        $past(st_reg.last_closed) : $past(st_reg.tuning_step_word)))
    else $error("wrong fallback word in holdover");
  clamp_bound_a: assert property (
    st_reg.clamp_lo <= st_reg.clamp_hi
    |=> TUNING_WORD >= $past(lo_word) && TUNING_WORD <= $past(hi_word))
    else $error("tuning word outside clamp");
  clamp_reset_a: assert property (
    $past(SYS_RST) |-> st_reg.clamp_lo == '0 && st_reg.clamp_hi == CLAMP_HI_RST)
    else $error("clamp limits wrong after reset");
  strobe_pulse_a: assert property (
    HIST_STROBE |-> HIST_VALID ##1 !HIST_STROBE)
    else $error("history strobe not a single pulse with valid history");
  clear_hist_a: assert property (
    clear_evt && !div_done |=> !HIST_VALID && st_reg.first)
    else $error("history not cleared");
  persist_keep_a: assert property (
    LOOP_IN.ref_switch && persist && !clear_evt && st_reg.valid
    |=> HIST_VALID && st_reg.hist == $past(st_reg.hist))
    else $error("persistent history lost on switch");
  first_store_a: assert property (
    !st_reg.valid && !div_done |=> !HIST_VALID)
    else $error("history appeared without a finished average");
  later_period_a: assert property (
    !st_reg.first && $stable(st_reg.timer) && !clear_evt && !LOOP_IN.ref_switch
    |=> st_reg.ckpt == st_reg.timer)
    else $error("later averages not at full interval");

  // selection extras and the history unit
  inside_pass_a: assert property (
    in_range |=> TUNING_WORD == $past(tw_sel))
    else $error("word inside the limits was altered");
  last_word_a: assert property (
    LOOP_IN.mode == DDSTW_CLOSED |=> st_reg.last_closed == TUNING_WORD)
    else $error("last closed-loop word not kept");
  switch_clear_a: assert property (
    LOOP_IN.ref_switch && !persist && !div_done |=> !HIST_VALID && st_reg.elapsed == '0)
    else $error("history kept across a plain reference switch");
  persist_restart_a: assert property (
    LOOP_IN.ref_switch && persist && !clear_evt |=> !st_reg.first && st_reg.elapsed == '0)
    else $error("accumulation not restarted on persistent switch");
  clear_ckpt_a: assert property (
    clear_evt |=> st_reg.first && st_reg.ckpt == $past(ckpt_init))
    else $error("first checkpoint wrong after clear");
  elapsed_hold_a: assert property (
    !ms_tick && !clear_evt && !LOOP_IN.ref_switch
    |=> st_reg.elapsed == $past(st_reg.elapsed))
    else $error("interval time moved between millisecond ticks");
  avg_start_a: assert property (
    $rose(st_reg.div_state == DIV_RUN) |-> st_reg.div_step == DIV_STEPS && st_reg.rem == '0)
    else $error("average started from a stale divider");
  hist_write_a: assert property (
    div_done |=> HIST_STROBE && HIST_VALID && st_reg.hist == st_reg.quot)
    else $error("finished average not stored");
  strobe_cause_a: assert property (
    !div_done |=> !HIST_STROBE)
    else $error("history strobe without a finished average");

  // ************************************************************
  // register bus checks
  // ************************************************************
  // the answer is registered from the setup cycle, so it lasts one cycle
  ready_pulse_a: assert property (
    APB_RSP.pready |=> !APB_RSP.pready)
    else $error("ready held past the access cycle");
  error_ready_a: assert property (
    APB_RSP.pslverr |-> APB_RSP.pready)
    else $error("slave error outside the access cycle");
  ftw_write_a: assert property (
    APB_REQ.psel && APB_REQ.penable && APB_RSP.pready && APB_REQ.pwrite && idx == IDX_FTW_LO
    |=> st_reg.tuning_step_word[DATA_W-1:0] == $past(APB_REQ.pwdata))
    else $error("free-run word write lost");

  strobe_c: cover property (HIST_STROBE);
  early_avg_c: cover property (HIST_STROBE && st_reg.first);
  hold_hist_c: cover property (LOOP_IN.mode == DDSTW_HOLDOVER && st_reg.valid);
  clamp_hit_c: cover property (!in_range);
  persist_sw_c: cover property (LOOP_IN.ref_switch && persist);

endmodule // ddstw_core

// *** verification/ddstw_loop_model.sv ***
module ddstw_loop_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commands from the bench
  input wire ddstw_pkg::ddstw_mode_t want_mode,
  input wire logic [ddstw_pkg::TW_W-1:0] want_word,
  input wire logic switch_req,
  // loop side of the core
  output ddstw_pkg::ddstw_loop_t loop_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddstw_pkg::*;
  logic switch_prev;
  // the loop controller updates mode and filter word on the sample clock only
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_out <= '{mode: DDSTW_FREE_RUN, ref_switch: 1'b0, filter_word: '0};
      switch_prev <= 1'b0;
    end else begin
      loop_out.mode <= want_mode;
      loop_out.filter_word <= want_word;
      // a held request still yields a single reselection pulse
      loop_out.ref_switch <= switch_req & ~switch_prev;
      switch_prev <= switch_req;
    end
  end
endmodule // ddstw_loop_model

// *** verification/dds_tuning_word_path_test.sv ***
module dds_tuning_word_path_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ddstw_pkg::*;
  localparam int MS = 100;
  localparam logic [TW_W-1:0] W1 = 48'h123456789abc;
  localparam logic [TW_W-1:0] W2 = 48'h2468ace02468;
  localparam logic [TW_W-1:0] W3 = 48'h0f0f0f0f0f0f;
  localparam logic [TW_W-1:0] W4 = 48'h3333_4444_5555;
  logic clk;
  logic sys_rst;
  ddstw_apb_req_t req;
  ddstw_apb_rsp_t rsp;
  ddstw_loop_t loop_in;
  logic pin;
  logic [TW_W-1:0] phase_out;
  logic [TW_W-1:0] tw;
  logic strobe;
  logic valid;
  ddstw_mode_t mode;
  logic [TW_W-1:0] word;
  logic sw;
  int errors;
  int check_count;
  logic [31:0] rd;
  logic err;

  ddstw_core #(.MS_CYCLES(MS)) i_ddstw_core (.CLK(clk), .SYS_RST(sys_rst), .APB_REQ(req),
    .APB_RSP(rsp), .LOOP_IN(loop_in), .CLEAR_HIST_PIN(pin), .PHASE_OUT(phase_out),
    .TUNING_WORD(tw), .HIST_STROBE(strobe), .HIST_VALID(valid));
  ddstw_loop_model i_ddstw_loop_model (.clk(clk), .rst(sys_rst), .want_mode(mode),
    .want_word(word), .switch_req(sw), .loop_out(loop_in));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    // read right after the edge, before its own updates land: the sampled values
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    if (n >= 50) check("pready", 1, 0);
    req <= '0;
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp, input string name);
    apb(1'b0, idx, 32'h0);
    check(name, exp, rd);
  endtask

  task automatic wr48(input logic [11:0] lo, input logic [47:0] v);
    apb(1'b1, lo, v[31:0]);
    apb(1'b1, lo + 12'h001, {16'h0, v[47:32]});
  endtask

  task automatic set_loop(input ddstw_mode_t m, input logic [47:0] w);
    @(posedge clk);
    mode <= m;
    word <= w;
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_strobe(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (strobe !== 1'b1 && c < 2000);
    if (c >= 2000) check("strobe", 1, 0);
  endtask

  task automatic pulse_switch;
    @(posedge clk);
    sw <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd_chk(IDX_CLAMP_LO, 32'h0, "clamp lo");
    rd_chk(IDX_CLAMP_HI, 32'h00ffffff, "clamp hi");
    rd_chk(IDX_TIMER, 32'h1, "timer");
    rd_chk(IDX_OPTIONS, 32'h0, "options");
    apb(1'b0, 12'h123, 32'h0);
    check("unmapped error", 1, err);
  endtask

  task automatic t_free_run;
    logic [47:0] p0;
    wr48(IDX_FTW_LO, 48'hc00000000001);
    repeat (3) @(posedge clk);
    check("free run word", 48'hc00000000001, tw);
    @(negedge clk);
    p0 = phase_out;
    @(negedge clk);
    check("phase step", 48'hc00000000001, phase_out - p0);
  endtask

  task automatic t_offset;
    logic [47:0] p0;
    wr48(IDX_FTW_LO, 48'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    p0 = phase_out;
    apb(1'b1, IDX_PHASE, 32'h1234);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("phase offset", 48'h123400000000, phase_out - p0);
  endtask

  task automatic t_clamp;
    set_loop(DDSTW_CLOSED, 48'h400000000000);
    check("loop word", 48'h400000000000, tw);
    apb(1'b1, IDX_CLAMP_LO, 32'h100000);
    apb(1'b1, IDX_CLAMP_HI, 32'h800000);
    set_loop(DDSTW_CLOSED, 48'h000000001000);
    check("lower clamp", 48'h100000000000, tw);
    set_loop(DDSTW_CLOSED, 48'hf00000000000);
    check("upper clamp", 48'h800000ffffff, tw);
    set_loop(DDSTW_CLOSED, 48'h400000000000);
    check("inside clamp", 48'h400000000000, tw);
    apb(1'b1, IDX_CLAMP_LO, 32'h0);
    apb(1'b1, IDX_CLAMP_HI, 32'hffffff);
  endtask

  task automatic t_history;
    int c;
    set_loop(DDSTW_CLOSED, W1);
    apb(1'b1, IDX_TIMER, 32'h2);
    apb(1'b1, IDX_CONTROL, 32'h4);
    wait_strobe(c);
    check("first interval", 1, c >= 2 * MS && c <= 2 * MS + 80);
    check("valid", 1, valid);
    @(posedge clk);
    word <= W2;
    wait_strobe(c);
    check("interval", 2 * MS, c);
    rd_chk(IDX_HIST_LO, W2[31:0], "history lo");
    rd_chk(IDX_HIST_HI, {16'h0, W2[47:32]}, "history hi");
    set_loop(DDSTW_HOLDOVER, W3);
    check("holdover word", W2, tw);
  endtask

  task automatic t_intermediate;
    int c;
    int gaps[4];
    gaps = '{MS, 2 * MS, 4 * MS, 4 * MS};
    set_loop(DDSTW_CLOSED, W1);
    apb(1'b1, IDX_TIMER, 32'h4);
    apb(1'b1, IDX_OPTIONS, 32'h2);
    apb(1'b1, IDX_CONTROL, 32'h4);
    wait_strobe(c);
    for (int i = 0; i < 4; i++) begin
      wait_strobe(c);
      check("strobe gap", gaps[i], c);
    end
  endtask

  task automatic t_switch;
    int c;
    apb(1'b1, IDX_TIMER, 32'h1);
    apb(1'b1, IDX_OPTIONS, 32'h0);
    wait_strobe(c);
    pulse_switch();
    check("valid after switch", 0, valid);
    apb(1'b1, IDX_OPTIONS, 32'h8);
    wait_strobe(c);
    pulse_switch();
    check("valid kept", 1, valid);
    @(posedge clk);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    check("valid after pin", 0, valid);
    pin <= 1'b0;
  endtask

  task automatic t_fallback;
    wr48(IDX_FTW_LO, W3);
    apb(1'b1, IDX_OPTIONS, 32'h0);
    set_loop(DDSTW_HOLDOVER, W1);
    check("fallback free run", W3, tw);
    set_loop(DDSTW_CLOSED, W4);
    apb(1'b1, IDX_OPTIONS, 32'h10);
    set_loop(DDSTW_HOLDOVER, W1);
    check("fallback last word", W4, tw);
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // clock, reset, sequence and watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    req = '0;
    pin = 1'b0;
    mode = DDSTW_FREE_RUN;
    word = '0;
    sw = 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_free_run();
    t_offset();
    t_clamp();
    t_history();
    t_intermediate();
    t_switch();
    t_fallback();
    conclude();
  end

  // the sequence needs roughly 2200 cycles; allow about nine times that
  initial begin
    #500000;
    errors++;
    $display("watchdog expired");
    conclude();
  end
endmodule // dds_tuning_word_path_test
